// file: common/ivpm_pkg.sv
package ivpm_pkg;

  // ---------------------------------------------------------------------------
  // Vector numbering
  // ---------------------------------------------------------------------------
  localparam int unsigned VEC_FIRST      = 7;
  localparam int unsigned VEC_LAST       = 66;
  localparam int unsigned NUM_SRC        = 60;
  localparam int unsigned VEC_W          = 7;
  localparam int unsigned SRC_W          = 6;

  localparam logic [6:0] VEC_DEBUG_BRK   = 7'h07;
  localparam logic [6:0] VEC_DEBUG_LAST  = 7'h0A;
  localparam logic [6:0] VEC_SWI2        = 7'h0B;
  localparam logic [6:0] VEC_SWI1        = 7'h0C;
  localparam logic [6:0] VEC_SWI0        = 7'h0D;
  localparam logic [6:0] VEC_LOW_VOLT    = 7'h0E;
  localparam logic [6:0] VEC_PLL_LOSS    = 7'h0F;
  localparam logic [6:0] VEC_PERIPH_LO   = 7'h10;
  localparam logic [6:0] VEC_TMRB_CH3    = 7'h10;
  localparam logic [6:0] VEC_ADC_LIMIT   = 7'h16;
  localparam logic [6:0] VEC_TMRA_CH3    = 7'h27;
  localparam logic [6:0] VEC_PWM_FAULT   = 7'h2B;
  localparam logic [6:0] VEC_PWM_CAPT3   = 7'h2E;
  localparam logic [6:0] VEC_FLASH_ERR   = 7'h36;
  localparam logic [6:0] VEC_FLASH_DONE  = 7'h37;
  localparam logic [6:0] VEC_FLASH_BUF   = 7'h38;
  localparam logic [6:0] VEC_CMP0        = 7'h39;
  localparam logic [6:0] VEC_CMP2        = 7'h3B;
  localparam logic [6:0] VEC_PERIPH_HI   = 7'h41;
  localparam logic [6:0] VEC_LOWEST_SW   = 7'h42;

  // ---------------------------------------------------------------------------
  // Addresses and levels
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 19;
  localparam int unsigned BASE_W         = 11;
  localparam int unsigned ENTRY_SHIFT    = 1;
  // Reset base lands vector 0 on the chip reset fetch address
  localparam logic [10:0] BASE_RESET     = 11'h000;
  localparam logic [18:0] RESET_FETCH    = 19'h00000;
  localparam logic [18:0] WDOG_FETCH     = 19'h00002;

  localparam logic [1:0]  LVL_0          = 2'h0;
  localparam logic [1:0]  LVL_1          = 2'h1;
  localparam logic [1:0]  LVL_2          = 2'h2;
  localparam logic [1:0]  LVL_3          = 2'h3;
  // Rank: 0 = no request, 1..4 = levels 0..3; lowest software takes rank 1 (level 0)
  localparam logic [2:0]  RANK_NONE      = 3'h0;
  localparam logic [2:0]  RANK_LOWEST    = 3'h1;

  typedef enum logic [1:0] {
    IVPM_IDLE = 2'b00,
    IVPM_POST = 2'b01,
    IVPM_WAIT = 2'b11
  } ivpm_state_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  vector;
    logic [18:0] offset;
    logic [2:0]  rank;
  } ivpm_req_t;

endpackage : ivpm_pkg

// file: dv/ivpm_assertions.sv
module ivpm_assertions
  import ivpm_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_rst_n,
  input wire logic                i_clk_en,
  input wire logic [10:0]         i_vector_base,
  input wire logic                i_ack,
  input wire ivpm_pkg::ivpm_req_t o_req,
  input wire logic [1:0]          o_level,
  input wire logic [18:0]         o_reset_fetch,
  input wire logic [18:0]         o_wdog_fetch
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Checks
  // ----
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [18:0] base;
  logic        v;
  logic [6:0]  vec;
  assign base = {i_vector_base, 8'h00};
  assign v    = o_req.valid;
  assign vec  = o_req.vector;
  property p_offset; v |-> o_req.offset == base + {vec, 1'b0}; endproperty
  a_offset: assert property (p_offset) else $error("offset wrong");
  property p_fetch; $stable(i_vector_base) && $past(i_clk_en) |-> o_reset_fetch == base && o_wdog_fetch == base + 19'h2;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch wrong");
  property p_hold; v && !i_ack |=> v && $stable(o_req); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_drop; v && $past(v) && $past(i_clk_en) && i_ack && i_clk_en |=> !v; endproperty
  a_drop: assert property (p_drop) else $error("ack not taken");
  property p_post; $rose(v) |-> ##1 v; endproperty
  a_post: assert property (p_post) else $error("short post");
  property p_lowest; v && vec == VEC_LOWEST_SW |-> o_req.rank == RANK_LOWEST && o_level == LVL_0; endproperty
  a_lowest: assert property (p_lowest) else $error("lowest rank");
  property p_periph; v && vec >= VEC_PERIPH_LO && vec <= VEC_PERIPH_HI |-> o_level != LVL_3 && o_req.rank == o_level + 3'h1;
  endproperty
  a_periph: assert property (p_periph) else $error("periph level");
  property p_hi; v && (vec <= VEC_DEBUG_LAST || vec == VEC_LOW_VOLT || vec == VEC_PLL_LOSS) |-> o_level != LVL_0;
  endproperty
  a_hi: assert property (p_hi) else $error("high level");
  property p_freeze; !i_clk_en |=> $stable(o_req) && $stable(o_level); endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  c_lowest: cover property (v && vec == VEC_LOWEST_SW);
  c_ack: cover property (v && i_ack ##1 !v);
  c_base: cover property (v && i_vector_base == 11'h7FF);
endmodule // ivpm_assertions

bind ivpm_top ivpm_assertions u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
  .i_vector_base(i_vector_base), .i_ack(i_ack), .o_req(o_req), .o_level(o_level),
  .o_reset_fetch(o_reset_fetch), .o_wdog_fetch(o_wdog_fetch));

// file: dv/ivpm_core_model.sv
module ivpm_core_model
  import ivpm_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  input  wire ivpm_pkg::ivpm_req_t i_req,
  input  wire logic [3:0]          i_delay,
  output logic                     o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // ack held until taken
  // Ack stays up until valid falls, so a frozen clock enable cannot lose it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 4'h0;
      o_ack  <= 1'b0;
    end else if (!i_req.valid) begin
      wait_q <= 4'h0;
      o_ack  <= 1'b0;
    end else if (wait_q == i_delay) begin
      o_ack  <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // ivpm_core_model

// file: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ivpm_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        clk_en  = 1'b1;
  logic [10:0] base    = 11'h000;
  logic [59:0] req     = 60'h0;
  logic [13:0] lh      = 14'h0;
  logic [99:0] lp      = 100'h0;
  logic [3:0]  dly     = 4'h1;
  logic        ack;
  ivpm_req_t   rq;
  logic [1:0]  lvl;
  logic [18:0] rf;
  logic [18:0] wf;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #5 i_clock = ~i_clock;
  // ----
  // Design and core
  // ----
  // Bit n of req is the source at vector n + 7
  ivpm_top DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_vector_base(base),
    .i_debug_unit_req(req[3:0]), .i_sw_req(req[6:4]), .i_power_monitor_req(req[7]), .i_pll_loss_req(req[8]),
    .i_timer_group_b_req(req[12:9]), .i_adc_req(req[15:13]), .i_can_req(req[19:16]),
    .i_serial_port_one_req(req[23:20]), .i_serial_port_zero_req(req[27:24]), .i_spi_req(req[29:28]),
    .i_i2c_req(req[31:30]), .i_timer_group_a_req(req[35:32]), .i_pwm_unit_req(req[46:36]),
    .i_flash_controller_req(req[49:47]), .i_comparator_req(req[52:50]), .i_gpio_req(req[58:53]),
    .i_lowest_software_request(req[59]), .i_level_hi(lh), .i_level_periph(lp), .i_ack(ack),
    .o_req(rq), .o_level(lvl), .o_reset_fetch(rf), .o_wdog_fetch(wf));
  ivpm_core_model u_core (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(rq), .i_delay(dly), .o_ack(ack));
  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [1:0] lvl_of(input int v);
    logic [1:0] c;
    if (v < 11 || v == 14 || v == 15) begin
      c = lh[(v < 11 ? 2 * (v - 7) : 2 * (v - 10)) +: 2];
      return (c == 2'h0) ? 2'h1 : c;
    end
    if (v < 14) return 2'(13 - v);
    if (v == 66) return 2'h0;
    c = lp[2 * (v - 16) +: 2];
    return (c == 2'h3) ? 2'h2 : c;
  endfunction
  task automatic serve(input int v);
    logic [18:0] exp;
    exp = {base, 8'h00} + 19'(2 * v);
    repeat (40) if (rq.valid !== 1'b1) @(posedge i_clock) #1;
    chk("vector", 19'(v), 19'(rq.vector));
    chk("offset", exp, rq.offset);
    chk("level", 19'(lvl_of(v)), 19'(lvl));
    chk("rank", 19'(lvl_of(v)) + 19'h1, 19'(rq.rank));
    @(posedge i_clock);
    req[v - 7] <= 1'b0;
    repeat (40) if (rq.valid === 1'b1) @(posedge i_clock) #1;
    chk("released", 19'h0, 19'(rq.valid));
  endtask
  task automatic t_reset();
    chk("reset fetch", 19'h00000, rf);
    chk("wdog fetch", 19'h00002, wf);
    $display("t_reset done");
  endtask
  task automatic t_map();
    int vl[20] = '{7, 10, 14, 15, 16, 19, 22, 39, 42, 43, 46, 53, 54, 55, 56, 57, 58, 59, 65, 66};
    lp <= {50{2'h3}};
    lh <= 14'h3F0;
    foreach (vl[i]) begin
      @(posedge i_clock);
      dly <= 4'(i % 4);
      req[vl[i] - 7] <= 1'b1;
      serve(vl[i]);
    end
    $display("t_map done");
  endtask
  task automatic t_prio();
    @(posedge i_clock);
    lp <= 100'h202;
    lh <= 14'h1;
    dly <= 4'h5;
    clk_en <= 1'b0;
    req <= 60'h820000000002201;
    repeat (3) @(posedge i_clock);
    clk_en <= 1'b1;
    serve(16);
    serve(20);
    serve(7);
    serve(60);
    serve(66);
    $display("t_prio done");
  endtask
  task automatic t_base();
    @(posedge i_clock);
    base <= 11'h7FF;
    repeat (3) @(posedge i_clock);
    #1;
    chk("base fetch", 19'h7FF00, rf);
    chk("base wdog", 19'h7FF02, wf);
    @(posedge i_clock);
    req[59] <= 1'b1;
    serve(66);
    $display("t_base done");
  endtask
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock) #1;
    t_reset();
    t_map();
    t_prio();
    t_base();
    complete_run();
  end
  // About 28 times the expected run length
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
endmodule // tb_top

// file: hw/ivpm_arbiter.sv
// -----------------------------------------------------------------------------
// Combinational ranking of pending sources
// -----------------------------------------------------------------------------
module ivpm_arbiter
  import ivpm_pkg::*;
(
  input  wire logic [59:0]  i_pending,
  input  wire logic [179:0] i_rank,
  output logic              o_valid,
  output logic [5:0]        o_index,
  output logic [2:0]        o_rank
);

  always_comb begin
    o_valid = 1'b0;
    o_index = 6'h00;
    o_rank  = RANK_NONE;
    // Scan from high index down so the lowest vector wins ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (i_pending[i] && (i_rank[i*3 +: 3] != RANK_NONE) && (i_rank[i*3 +: 3] >= o_rank)) begin
        o_valid = 1'b1;
        o_index = SRC_W'(i);
        o_rank  = i_rank[i*3 +: 3];
      end
    end
  end

endmodule // ivpm_arbiter

// file: hw/ivpm_top.sv
// Behaviour
// [RL1] Each vector's entry address is the vector base plus twice the vector number.
// [RL2] The four debug-unit sources at vectors 7 to 10 take a programmable level of 1 to 3.
// [RL3] Low-voltage (14) and PLL loss (15) take a programmable level of 1 to 3.
// [RL4] Peripheral sources 16 to 65 take only levels 0 to 2; the converter limit request is 22.
// [RL5] Timer group B channels 3..0 use vectors 16..19 and group A channels 3..0 use 39..42.
// [RL6] PWM uses 43 to 53, with the only input-capture request at 46 for submodule 3.
// [RL7] Flash raises access error at 54, command complete at 55 and buffer empty at 56.
// [RL8] Comparators 0, 1 and 2 raise their edge flags at vectors 57, 58 and 59.
// [RL9] The lowest software request at 66 sits below every level and wins only when alone.
// [RL10] With the base at reset value, entries 0 and 1 coincide with the reset fetch addresses.
// [RL11] Higher level wins first, and within a level the lowest vector wins.
// [RL12] Two-word entries limit the reachable entry address to 19 bits.
// [RL13] The winning request's offset and level are held for the core until it acknowledges.
module ivpm_top
  import ivpm_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_clk_en,
  input  wire logic [10:0]          i_vector_base,
  input  wire logic [3:0]           i_debug_unit_req,
  input  wire logic [2:0]           i_sw_req,
  input  wire logic                 i_power_monitor_req,
  input  wire logic                 i_pll_loss_req,
  input  wire logic [3:0]           i_timer_group_b_req,
  input  wire logic [2:0]           i_adc_req,
  input  wire logic [3:0]           i_can_req,
  input  wire logic [3:0]           i_serial_port_one_req,
  input  wire logic [3:0]           i_serial_port_zero_req,
  input  wire logic [1:0]           i_spi_req,
  input  wire logic [1:0]           i_i2c_req,
  input  wire logic [3:0]           i_timer_group_a_req,
  input  wire logic [10:0]          i_pwm_unit_req,
  input  wire logic [2:0]           i_flash_controller_req,
  input  wire logic [2:0]           i_comparator_req,
  input  wire logic [5:0]           i_gpio_req,
  input  wire logic                 i_lowest_software_request,
  input  wire logic [13:0]          i_level_hi,
  input  wire logic [99:0]          i_level_periph,
  input  wire logic                 i_ack,
  output ivpm_pkg::ivpm_req_t       o_req,
  output logic [1:0]                o_level,
  output logic [18:0]               o_reset_fetch,
  output logic [18:0]               o_wdog_fetch
);
  import ivpm_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // [RL1] base plus twice vector
  function automatic logic [18:0] entry_addr(input logic [10:0] base, input logic [6:0] vec);
    logic [18:0] b;
    logic [18:0] v;
    b = {base, 8'h00};
    v = {11'h000, vec, 1'b0};
    // [RL12] 19-bit wrap
    entry_addr = b + v;
  endfunction

  // Level 1..3 field; a code of 0 is pulled up to 1
  function automatic logic [2:0] rank_1to3(input logic [1:0] lvl);
    rank_1to3 = (lvl == LVL_0) ? 3'h2 : {1'b0, lvl} + 3'h1;
  endfunction

  // Level 0..2 field; a code of 3 is clamped to 2
  function automatic logic [2:0] rank_0to2(input logic [1:0] lvl);
    rank_0to2 = (lvl == LVL_3) ? 3'h3 : {1'b0, lvl} + 3'h1;
  endfunction

  // ---------------------------------------------------------------------------
  // Source flattening, index 0 = vector 7
  // ---------------------------------------------------------------------------
  logic [59:0]  src_req;
  logic [179:0] src_rank;

  // [RL5] [RL6] [RL7] [RL8] vector placement
  assign src_req = {
    i_lowest_software_request,
    i_gpio_req,
    i_comparator_req,
    i_flash_controller_req,
    i_pwm_unit_req,
    i_timer_group_a_req,
    i_i2c_req,
    i_spi_req,
    i_serial_port_zero_req,
    i_serial_port_one_req,
    i_can_req,
    i_adc_req,
    i_timer_group_b_req,
    i_pll_loss_req,
    i_power_monitor_req,
    i_sw_req,
    i_debug_unit_req
  };

  always_comb begin
    src_rank = '0;
    // [RL2] debug 1..3
    for (int i = 0; i < 4; i++) begin
      src_rank[i*3 +: 3] = rank_1to3(i_level_hi[i*2 +: 2]);
    end
    // Fixed software levels 2, 1, 0
    src_rank[4*3 +: 3] = 3'h3;
    src_rank[5*3 +: 3] = 3'h2;
    src_rank[6*3 +: 3] = 3'h1;
    // [RL3] power monitor and PLL 1..3
    src_rank[7*3 +: 3] = rank_1to3(i_level_hi[8 +: 2]);
    src_rank[8*3 +: 3] = rank_1to3(i_level_hi[10 +: 2]);
    // [RL4] peripherals 0..2
    for (int i = 0; i < 50; i++) begin
      src_rank[(i+9)*3 +: 3] = rank_0to2(i_level_periph[i*2 +: 2]);
    end
    // [RL9] below every level
    src_rank[59*3 +: 3] = RANK_LOWEST;
  end

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  logic       win_valid;
  logic [5:0] win_index;
  logic [2:0] win_rank;

  // [RL11] level then vector
  ivpm_arbiter u_arbiter (
    .i_pending (src_req),
    .i_rank    (src_rank),
    .o_valid   (win_valid),
    .o_index   (win_index),
    .o_rank    (win_rank)
  );

  logic [6:0] win_vec;
  assign win_vec = {1'b0, win_index} + 7'(VEC_FIRST);

  // ---------------------------------------------------------------------------
  // Hand-off to the core
  // ---------------------------------------------------------------------------
  ivpm_state_t state_q;
  ivpm_req_t   req_q;
  logic [1:0]  level_q;

  // [RL13] post then hold till ack
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= IVPM_IDLE;
    end else if (i_clk_en) begin
      case (state_q)
        IVPM_IDLE: begin
          if (win_valid) begin
            state_q <= IVPM_POST;
          end
        end
        IVPM_POST: begin
          state_q <= IVPM_WAIT;
        end
        IVPM_WAIT: begin
          if (i_ack) begin
            state_q <= IVPM_IDLE;
          end
        end
        default: begin
          state_q <= IVPM_IDLE;
        end
      endcase
    end
  end

  // Captured once; a later, higher request waits until the ack
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q   <= '0;
      level_q <= LVL_0;
    end else if (i_clk_en) begin
      if (state_q == IVPM_IDLE && win_valid) begin
        req_q.valid  <= 1'b1;
        req_q.vector <= win_vec;
        req_q.offset <= entry_addr(i_vector_base, win_vec);
        req_q.rank   <= win_rank;
        // Rank is level plus one; the lowest software rank reads back as level 0
        level_q      <= (win_rank > RANK_NONE) ? 2'(win_rank - 3'h1) : LVL_0;
      end else if (state_q == IVPM_WAIT && i_ack) begin
        req_q.valid  <= 1'b0;
      end
    end
  end

  // [RL10] entries 0 and 1 for the core's reset fetch
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reset_fetch <= RESET_FETCH;
      o_wdog_fetch  <= WDOG_FETCH;
    end else if (i_clk_en) begin
      o_reset_fetch <= entry_addr(i_vector_base, 7'h00);
      o_wdog_fetch  <= entry_addr(i_vector_base, 7'h01);
    end
  end

  assign o_req   = req_q;
  assign o_level = level_q;

endmodule // ivpm_top
